// File: hw/dec_event_counter.v
// Purpose: control and counting logic of two edge-triggered event counters
// Assumes: a serial bus front end presents byte accesses on the register port
// Notes:   counter offsets read the snapshot; writes load the live counters
`timescale 1ns/1ps
`default_nettype none
`include "dec_map.vh"

module dec_event_counter #(
   parameter BYTE_W = 8
) (
   input  wire              clock,
   input  wire              rst,
   input  wire              first_event_input,
   input  wire              second_event_input,
   input  wire [7:0]        reg_addr,
   input  wire              reg_wr,
   input  wire [BYTE_W-1:0] reg_wdata,
   input  wire              reg_rd,
   output reg  [BYTE_W-1:0] reg_rdata,
   output reg               reg_rvalid,
   output wire              cascade_select,
   output wire              capture_snapshot_cmd
);

   wire first_rise;
   wire first_fall;
   wire second_rise;
   wire second_fall;
   wire [1:0] event_pins;
   wire [1:0] rise_pulses;
   wire [1:0] fall_pulses;

   reg  first_input_polarity_q;
   reg  second_input_polarity_q;
   reg  cascade_select_q;
   reg  capture_cmd_q;

   reg  [BYTE_W-1:0] c1_lo_q;
   reg  [BYTE_W-1:0] c1_hi_q;
   reg  [BYTE_W-1:0] c2_lo_q;
   reg  [BYTE_W-1:0] c2_hi_q;
   reg  [BYTE_W-1:0] s1_lo_q;
   reg  [BYTE_W-1:0] s1_hi_q;
   reg  [BYTE_W-1:0] s2_lo_q;
   reg  [BYTE_W-1:0] s2_hi_q;

   reg  first_event;
   reg  second_event;
   reg  c1_lo_wrap;
   reg  c1_full;
   reg  inc_c2;
   reg  c2_lo_wrap;

   wire wr_setup;
   wire wr_c1_lo;
   wire wr_c1_hi;
   wire wr_c2_lo;
   wire wr_c2_hi;

   // one synchroniser and edge detector per event pin
   assign event_pins = {second_event_input, first_event_input};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_edge
         dec_edge_detect u_edge (
            .clock      (clock),
            .rst        (rst),
            .pin        (event_pins[ch]),
            .rise_pulse (rise_pulses[ch]),
            .fall_pulse (fall_pulses[ch])
         );
      end
   endgenerate

   assign first_rise  = rise_pulses[0];
   assign first_fall  = fall_pulses[0];
   assign second_rise = rise_pulses[1];
   assign second_fall = fall_pulses[1];

   assign cascade_select       = cascade_select_q;
   assign capture_snapshot_cmd = capture_cmd_q;

   assign wr_setup = reg_wr && (reg_addr == `DEC_OFF_SETUP);
   assign wr_c1_lo = reg_wr && (reg_addr == `DEC_OFF_FIRST_EVENT_INPUT_LO);
   assign wr_c1_hi = reg_wr && (reg_addr == `DEC_OFF_FIRST_EVENT_INPUT_HI);
   assign wr_c2_lo = reg_wr && (reg_addr == `DEC_OFF_SECOND_EVENT_INPUT_LO);
   assign wr_c2_hi = reg_wr && (reg_addr == `DEC_OFF_SECOND_EVENT_INPUT_HI);

   always @* begin
      first_event = first_input_polarity_q ? first_rise : first_fall;
      second_event = second_input_polarity_q ? second_rise : second_fall;
      c1_lo_wrap = first_event && (c1_lo_q == `DEC_BYTE_ALL_ONES);
      c1_full    = c1_lo_wrap && (c1_hi_q == `DEC_BYTE_ALL_ONES);
      if (cascade_select_q) begin
         inc_c2 = c1_full;
      end else begin
         inc_c2 = second_event;
      end
      c2_lo_wrap = inc_c2 && (c2_lo_q == `DEC_BYTE_ALL_ONES);
   end

   // control register; a capture write is served on the following clock
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         first_input_polarity_q  <= 1'b0;
         second_input_polarity_q <= 1'b0;
         cascade_select_q        <= 1'b0;
         capture_cmd_q           <= 1'b0;
      end else begin
         if (wr_setup) begin
            first_input_polarity_q  <= reg_wdata[`DEC_BIT_FIRST_POL];
            second_input_polarity_q <= reg_wdata[`DEC_BIT_SECOND_POL];
            cascade_select_q        <= reg_wdata[`DEC_BIT_CASCADE];
         end
         if (wr_setup && reg_wdata[`DEC_BIT_CAPTURE]) begin
            capture_cmd_q <= 1'b1;
         end else if (capture_cmd_q) begin
            capture_cmd_q <= 1'b0;
         end
      end
   end

   // live counters never pause
   // a host write to a counter byte wins over an edge in the same cycle
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         c1_lo_q <= `DEC_BYTE_RST;
         c1_hi_q <= `DEC_BYTE_RST;
         c2_lo_q <= `DEC_BYTE_RST;
         c2_hi_q <= `DEC_BYTE_RST;
      end else begin
         if (wr_c1_lo) begin
            c1_lo_q <= reg_wdata;
         end else if (first_event) begin
            c1_lo_q <= c1_lo_q + 1'b1;
         end
         if (wr_c1_hi) begin
            c1_hi_q <= reg_wdata;
         end else if (c1_lo_wrap) begin
            c1_hi_q <= c1_hi_q + 1'b1;
         end
         if (wr_c2_lo) begin
            c2_lo_q <= reg_wdata;
         end else if (inc_c2) begin
            c2_lo_q <= c2_lo_q + 1'b1;
         end
         if (wr_c2_hi) begin
            c2_hi_q <= reg_wdata;
         end else if (c2_lo_wrap) begin
            c2_hi_q <= c2_hi_q + 1'b1;
         end
      end
   end

   // snapshot copy
   // the host reads a stable copy so a carry between byte reads cannot tear it
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         s1_lo_q <= `DEC_BYTE_RST;
         s1_hi_q <= `DEC_BYTE_RST;
         s2_lo_q <= `DEC_BYTE_RST;
         s2_hi_q <= `DEC_BYTE_RST;
      end else if (capture_cmd_q) begin
         s1_lo_q <= c1_lo_q;
         s1_hi_q <= c1_hi_q;
         s2_lo_q <= c2_lo_q;
         s2_hi_q <= c2_hi_q;
      end
   end

   // read port: data one clock after the strobe, unmapped reads give zero
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata  <= `DEC_READ_ZERO;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (!reg_rd) begin
            reg_rdata <= `DEC_READ_ZERO;
         end else if (reg_addr == `DEC_OFF_SETUP) begin
            reg_rdata <= {4'h0, capture_cmd_q, cascade_select_q,
                          second_input_polarity_q, first_input_polarity_q};
         end else if (reg_addr == `DEC_OFF_FIRST_EVENT_INPUT_LO) begin
            reg_rdata <= s1_lo_q;
         end else if (reg_addr == `DEC_OFF_FIRST_EVENT_INPUT_HI) begin
            reg_rdata <= s1_hi_q;
         end else if (reg_addr == `DEC_OFF_SECOND_EVENT_INPUT_LO) begin
            reg_rdata <= s2_lo_q;
         end else if (reg_addr == `DEC_OFF_SECOND_EVENT_INPUT_HI) begin
            reg_rdata <= s2_hi_q;
         end else begin
            reg_rdata <= `DEC_READ_ZERO;
         end
      end
   end

endmodule // dec_event_counter

`default_nettype wire

// File: hw/dec_map.vh
// Purpose: constants for the dual event counter control block
// Assumes: 8-bit register port behind the serial bus front end
// Notes:   offsets are the byte addresses seen by the host
`ifndef DEC_MAP_VH
`define DEC_MAP_VH

// register offsets
`define DEC_OFF_FIRST_EVENT_INPUT_LO     8'h0D
`define DEC_OFF_FIRST_EVENT_INPUT_HI     8'h0E
`define DEC_OFF_SECOND_EVENT_INPUT_LO     8'h0F
`define DEC_OFF_SECOND_EVENT_INPUT_HI     8'h10
`define DEC_OFF_SETUP       8'h0C

// edge_counter_setup field positions
`define DEC_BIT_FIRST_POL   0
`define DEC_BIT_SECOND_POL  1
`define DEC_BIT_CASCADE     2
`define DEC_BIT_CAPTURE     3

// reset values and fixed byte constants
`define DEC_SETUP_RST       4'h0
`define DEC_BYTE_RST        8'h00
`define DEC_BYTE_ALL_ONES   8'hFF
`define DEC_READ_ZERO       8'h00

// synchroniser depth in front of the event pins
`define DEC_SYNC_STAGES     2

`endif

// File: hw/dec_edge_detect.v
// Purpose: synchronise one event pin and report its rising and falling edges
// Assumes: pin is asynchronous to clock
// Notes:   edges are one-cycle pulses, three clocks after the pin moves
`timescale 1ns/1ps
`default_nettype none
`include "dec_map.vh"

module dec_edge_detect (
   input  wire clock,
   input  wire rst,
   input  wire pin,
   output reg  rise_pulse,
   output reg  fall_pulse
);

   reg  sync1_q;
   reg  sync2_q;
   reg  prev_q;

   // first stage feeds only the second stage
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_q    <= 1'b0;
         sync2_q    <= 1'b0;
         prev_q     <= 1'b0;
         rise_pulse <= 1'b0;
         fall_pulse <= 1'b0;
      end else begin
         sync1_q    <= pin;
         sync2_q    <= sync1_q;
         prev_q     <= sync2_q;
         rise_pulse <= sync2_q & ~prev_q;
         fall_pulse <= ~sync2_q & prev_q;
      end
   end

endmodule // dec_edge_detect

`default_nettype wire

// File: tb/dec_host_model.sv
// Purpose: host side of the register port
// Assumes: bus lines change at the falling edge
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dec_host_model (
   input  wire logic       clock,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   output var  logic [7:0] reg_addr,
   output var  logic       reg_wr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      int i;
      @(negedge clock);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      reg_addr = ~a;
      // bounded wait so a silent design cannot hang the run
      for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++) @(negedge clock);
      ok = (reg_rvalid === 1'b1);
      d = reg_rdata;
   endtask
endmodule // dec_host_model
`default_nettype wire

// File: tb/dec_event_counter_sva.sv
// Purpose: port checker for the event counter block
// Assumes: rising edge clock, rst async active high
// Notes:   bound to the block below
`timescale 1ns/1ps
`default_nettype none
module dec_event_counter_sva (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   input wire logic       cascade_select,
   input wire logic       capture_snapshot_cmd
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic set_wr = reg_wr && reg_addr == 8'h0C;
   wire logic cap_wr = set_wr && reg_wdata[3];
   a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read unanswered");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
   a_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 8'h00) else $error("rdata not 0");
   a_cap_set: assert property (cap_wr |=> capture_snapshot_cmd) else $error("no capture");
   a_cap_clear: assert property (capture_snapshot_cmd && !cap_wr |=> !capture_snapshot_cmd)
      else $error("capture stuck");
   a_cap_cause: assert property ($rose(capture_snapshot_cmd) |-> $past(cap_wr))
      else $error("capture uncaused");
   a_casc_on: assert property (set_wr && reg_wdata[2] |=> cascade_select)
      else $error("cascade not set");
   a_casc_off: assert property (set_wr && !reg_wdata[2] |=> !cascade_select)
      else $error("cascade not cleared");
   a_casc_hold: assert property (!set_wr |=> $stable(cascade_select)) else $error("cascade moved");
   a_upper_zero: assert property (reg_rvalid && $past(reg_addr) == 8'h0C |-> reg_rdata[7:4] == 4'h0)
      else $error("upper bits set");
endmodule // dec_event_counter_sva
bind dec_event_counter dec_event_counter_sva u_sva (.clock(clock), .rst(rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cascade_select(cascade_select),
   .capture_snapshot_cmd(capture_snapshot_cmd));
`default_nettype wire

// File: tb/dec_event_counter_test.sv
// Purpose: self-checking bench for the event counter block
// Assumes: pins and bus driven at the falling edge
// Notes:   pins hold each level 5 clocks, above the 2 required
`timescale 1ns/1ps
`default_nettype none
module dec_event_counter_test;
   logic        clock, rst, p1, p2, wr, rd, rvalid, casc, cap, ok;
   logic [7:0]  addr, wdata, rdata, d, cfg;
   logic [15:0] e1, e2;
   int          mismatches, n_tests, t, k;
   dec_event_counter u_dut (.clock(clock), .rst(rst), .first_event_input(p1),
      .second_event_input(p2), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid), .cascade_select(casc),
      .capture_snapshot_cmd(cap));
   dec_host_model u_host (.clock(clock), .reg_rdata(rdata), .reg_rvalid(rvalid),
      .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, d, ok);
      if (!ok) begin
         mismatches++;
         stop_test();
      end else begin
         chk(n, e, d);
      end
   endtask
   // expected counts follow the edge choice and the cascade carry
   task step(input logic a, input logic b);
      @(negedge clock);
      if (a != p1 && a == cfg[0]) e1 = e1 + 16'h0001;
      if (cfg[2] && a != p1 && a == cfg[0] && e1 == 16'h0000) e2 = e2 + 16'h0001;
      if (!cfg[2] && b != p2 && b == cfg[1]) e2 = e2 + 16'h0001;
      p1 = a;
      p2 = b;
      repeat (4) @(negedge clock);
   endtask
   task snap;
      u_host.wr(8'h0C, {5'h01, cfg[2:0]});
      chk("capture", 8'h01, {7'h00, cap});
      rchk("first_event_input_lo", 8'h0D, e1[7:0]);
      rchk("first_event_input_hi", 8'h0E, e1[15:8]);
      rchk("second_event_input_lo", 8'h0F, e2[7:0]);
      rchk("second_event_input_hi", 8'h10, e2[15:8]);
      rchk("setup", 8'h0C, {5'h00, cfg[2:0]});
   endtask
   initial begin
      rst = 1'b1;
      p1 = 1'b0;
      p2 = 1'b0;
      mismatches = 0;
      n_tests = 0;
      k = $urandom(32'hC483E468);
      repeat (20) @(negedge clock);
      rst = 1'b0;
      rchk("setup_rst", 8'h0C, 8'h00);
      rchk("unmapped", 8'h20, 8'h00);
      for (t = 0; t < 8; t++) begin
         cfg = 8'($urandom);
         cfg[2] = t[0];
         u_host.wr(8'h0C, {cfg[7:4], 1'b0, cfg[2:0]});
         chk("cascade", {7'h00, cfg[2]}, {7'h00, casc});
         e1 = {t < 2 ? 8'hFF : 8'($urandom), 8'hFE};
         e2 = 16'($urandom);
         for (k = 0; k < 4; k++) u_host.wr(8'h0D + 8'(k), 8'({e2, e1} >> (8 * k)));
         for (k = 0; k < 12; k++) begin
            step(1'($urandom), 1'($urandom));
            if (k == 5) snap();
         end
         snap();
         $display("test %0d done", t);
      end
      stop_test();
   end
endmodule // dec_event_counter_test
`default_nettype wire
